//--- verilog/bim_pkg.sv
/*
 * Package of the bias and input multiplexer configuration block:
 * register indices, field positions, reset values, decode tables and
 * the packed structs that carry the configuration and the decoded
 * analog controls.
 * Assumes a single system clock and a word-wide AHB-Lite register bus.
 */
// Overview of operation
// - Decode lead-off threshold: 300, 400, 450, 500 mV
// - Bias mode 10 active only with channel enable
// - Non-zero bias mode write needs channel enable
// - Bias resistor codes give 50, 100, 200 megaohm
// - Positive input bias bit connects bias resistor
// - Negative input bias bit connects bias resistor
// - Output rate from clock code and rate bit
// - Calibration timing step follows master clock
// - Positive isolation bit opens positive input switch
// - Negative isolation bit opens negative input switch
// - Positive calibration code 01 ties to mid-supply
// - Negative calibration code 01 ties to mid-supply
// - Current generator mode selects chopping and filter
// - Self-test bit enables modulated resistance test
// - Self-test isolates drives, routes them, forces 200M bias
// - Channel enable bit powers the channel
// - Two-bit field selects master clock frequency
package bim_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [7:0] GEN_IDX = 8'h10;  // General configuration
    localparam logic [7:0] BMUX_IDX = 8'h17; // Input mux configuration
    localparam logic [7:0] RATE_IDX = 8'h20; // Output rate control

    // ==========================================================
    // Field positions, general configuration
    // ==========================================================
    localparam int GEN_MCLK_POS = 20;  // Master clock select, 2 bits
    localparam int GEN_CHEN_POS = 18;  // Channel enable
    localparam int GEN_VTH_POS = 6;    // Lead-off threshold, 2 bits
    localparam int GEN_RBMODE_POS = 4; // Resistive bias mode, 2 bits
    localparam int GEN_RBSEL_POS = 2;  // Bias resistance, 2 bits
    localparam int GEN_BIASP_POS = 1;  // Positive input bias
    localparam int GEN_BIASN_POS = 0;  // Negative input bias

    // ==========================================================
    // Field positions, input mux and rate control
    // ==========================================================
    localparam int BMUX_ISOP_POS = 21; // Positive input isolate
    localparam int BMUX_ISON_POS = 20; // Negative input isolate
    localparam int BMUX_CALP_POS = 18; // Positive calibration, 2 bits
    localparam int BMUX_CALN_POS = 16; // Negative calibration, 2 bits
    localparam int BMUX_CG_POS = 12;   // Current generator mode, 2 bits
    localparam int BMUX_BIST_POS = 11; // Self-test enable
    localparam int RATE_SEL_POS = 0;   // Half-rate select

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [1:0] RST_MCLK = 2'h0;
    localparam logic RST_CHEN = 1'h0;
    localparam logic [1:0] RST_VTH = 2'h0;
    localparam logic [1:0] RST_RBMODE = 2'h0;
    localparam logic [1:0] RST_RBSEL = 2'h1;
    localparam logic RST_BIAS = 1'h0;
    localparam logic RST_ISO = 1'h1;
    localparam logic [1:0] RST_CAL = 2'h0;
    localparam logic [1:0] RST_CG = 2'h0;
    localparam logic RST_BIST = 1'h0;
    localparam logic RST_RATE = 1'h0;

    // ==========================================================
    // Field codes
    // ==========================================================
    localparam logic [1:0] RBMODE_OFF = 2'h0; // Resistive bias off
    localparam logic [1:0] RBMODE_ON = 2'h2;  // Resistive bias on
    localparam logic [1:0] CAL_MID = 2'h1;    // Tie input to mid-supply
    localparam logic [1:0] CG_UNCH_LP = 2'h0; // Unchopped, low-pass
    localparam logic [1:0] CG_CH_NOLP = 2'h1; // Chopped, no low-pass
    localparam logic [1:0] CG_CH_LP = 2'h2;   // Chopped, low-pass
    localparam logic [1:0] CG_CH_RCM = 2'h3;  // Chopped, resistive CM

    // ==========================================================
    // Decode tables
    // ==========================================================
    localparam logic [9:0] VTH_MV_0 = 10'h12C;
    localparam logic [9:0] VTH_MV_1 = 10'h190;
    localparam logic [9:0] VTH_MV_2 = 10'h1C2;
    localparam logic [9:0] VTH_MV_3 = 10'h1F4;
    localparam logic [7:0] RBIAS_M_0 = 8'h32;
    localparam logic [7:0] RBIAS_M_1 = 8'h64;
    localparam logic [7:0] RBIAS_M_2 = 8'hC8;
    localparam logic [7:0] RBIAS_SELFTEST = 8'hC8;
    // Master clock in hundredths of a hertz
    localparam logic [21:0] FMC_CHZ_0 = 22'h320000;
    localparam logic [21:0] FMC_CHZ_1 = 22'h30D400;
    localparam logic [21:0] FMC_CHZ_2 = 22'h30D400;
    localparam logic [21:0] FMC_CHZ_3 = 22'h30C7CE;
    // Calibration timing step in nanoseconds, one master clock period
    localparam logic [14:0] CAL_NS_0 = 15'h7736;
    localparam logic [14:0] CAL_NS_1 = 15'h7A12;
    localparam logic [14:0] CAL_NS_2 = 15'h7A12;
    localparam logic [14:0] CAL_NS_3 = 15'h7A31;
    // Output rate in hundredths of a sample per second
    localparam logic [12:0] RATE_F_0 = 13'h1900;
    localparam logic [12:0] RATE_H_0 = 13'h0C80;
    localparam logic [12:0] RATE_F_1 = 13'h186A;
    localparam logic [12:0] RATE_H_1 = 13'h0C35;
    localparam logic [12:0] RATE_F_2 = 13'h1388;
    localparam logic [12:0] RATE_H_2 = 13'h09C4;
    localparam logic [12:0] RATE_F_3 = 13'h1383;
    localparam logic [12:0] RATE_H_3 = 13'h09C2;

    // ==========================================================
    // Types
    // ==========================================================
    // Register selected by a pending write
    typedef enum logic [1:0] {
        REG_NONE,
        REG_GEN,
        REG_BMUX,
        REG_RATE
    } bim_reg_e;

    // Stored configuration fields
    typedef struct packed {
        logic [1:0] master_clock_sel;
        logic channel_enable;
        logic [1:0] leadoff_threshold_sel;
        logic [1:0] resistive_bias_mode;
        logic [1:0] bias_resistance_sel;
        logic pos_input_bias_en;
        logic neg_input_bias_en;
        logic pos_input_isolate;
        logic neg_input_isolate;
        logic [1:0] pos_calibration_sel;
        logic [1:0] neg_calibration_sel;
        logic [1:0] current_generator_mode;
        logic selftest_enable;
        logic rate_half;
    } bim_cfg_s;

    // Decoded controls for the analog switches and sources
    typedef struct packed {
        logic channel_power;
        logic [1:0] master_clock_sel;
        logic [21:0] master_freq_chz;
        logic [14:0] cal_step_ns;
        logic [12:0] sample_rate_csps;
        logic [9:0] leadoff_threshold_mv;
        logic [7:0] bias_resistance_mohm;
        logic pos_bias_connect;
        logic neg_bias_connect;
        logic pos_input_connect;
        logic neg_input_connect;
        logic pos_cal_mid;
        logic neg_cal_mid;
        logic cg_chopped;
        logic cg_lowpass;
        logic cg_resistive_cm;
        logic modulated_resistance_en;
        logic drive_outputs_isolate;
        logic drive_to_input_close;
    } bim_ctrl_s;

endpackage : bim_pkg

//--- verilog/bim_decode.sv
/*
 * Combinational decode of the stored configuration into the controls
 * of the analog switches, sources and timing of the channel.
 * Assumes the caller registers the result before it leaves the block.
 */
`timescale 1ns/1ps
module bim_decode (
    input wire bim_pkg::bim_cfg_s cfg_i,
    output bim_pkg::bim_ctrl_s ctrl_o
);

    // ==========================================================
    // Decode
    // ==========================================================
    // One pass over every field
    always_comb begin
        ctrl_o = '0;
        ctrl_o.channel_power = cfg_i.channel_enable;
        ctrl_o.master_clock_sel = cfg_i.master_clock_sel;
        // Clock, calibration step and output rate by clock code
        unique case (cfg_i.master_clock_sel)
            2'h0: begin
                ctrl_o.master_freq_chz = bim_pkg::FMC_CHZ_0;
                ctrl_o.cal_step_ns = bim_pkg::CAL_NS_0;
                ctrl_o.sample_rate_csps = cfg_i.rate_half ?
                    bim_pkg::RATE_H_0 : bim_pkg::RATE_F_0;
            end
            2'h1: begin
                ctrl_o.master_freq_chz = bim_pkg::FMC_CHZ_1;
                ctrl_o.cal_step_ns = bim_pkg::CAL_NS_1;
                ctrl_o.sample_rate_csps = cfg_i.rate_half ?
                    bim_pkg::RATE_H_1 : bim_pkg::RATE_F_1;
            end
            2'h2: begin
                ctrl_o.master_freq_chz = bim_pkg::FMC_CHZ_2;
                ctrl_o.cal_step_ns = bim_pkg::CAL_NS_2;
                ctrl_o.sample_rate_csps = cfg_i.rate_half ?
                    bim_pkg::RATE_H_2 : bim_pkg::RATE_F_2;
            end
            2'h3: begin
                ctrl_o.master_freq_chz = bim_pkg::FMC_CHZ_3;
                ctrl_o.cal_step_ns = bim_pkg::CAL_NS_3;
                ctrl_o.sample_rate_csps = cfg_i.rate_half ?
                    bim_pkg::RATE_H_3 : bim_pkg::RATE_F_3;
            end
        endcase
        // Lead-off comparator window around mid-supply
        unique case (cfg_i.leadoff_threshold_sel)
            2'h0: ctrl_o.leadoff_threshold_mv = bim_pkg::VTH_MV_0;
            2'h1: ctrl_o.leadoff_threshold_mv = bim_pkg::VTH_MV_1;
            2'h2: ctrl_o.leadoff_threshold_mv = bim_pkg::VTH_MV_2;
            2'h3: ctrl_o.leadoff_threshold_mv = bim_pkg::VTH_MV_3;
        endcase
        // Bias resistor; reserved code leaves no resistor value
        unique case (cfg_i.bias_resistance_sel)
            2'h0: ctrl_o.bias_resistance_mohm = bim_pkg::RBIAS_M_0;
            2'h1: ctrl_o.bias_resistance_mohm = bim_pkg::RBIAS_M_1;
            2'h2: ctrl_o.bias_resistance_mohm = bim_pkg::RBIAS_M_2;
            2'h3: ctrl_o.bias_resistance_mohm = 8'h00;
        endcase
        // Resistive bias only in mode 10 with the channel powered
        if (cfg_i.resistive_bias_mode == bim_pkg::RBMODE_ON &&
            cfg_i.channel_enable) begin
            ctrl_o.pos_bias_connect = cfg_i.pos_input_bias_en;
            ctrl_o.neg_bias_connect = cfg_i.neg_input_bias_en;
        end
        // Input switches and calibration ties
        ctrl_o.pos_input_connect = !cfg_i.pos_input_isolate;
        ctrl_o.neg_input_connect = !cfg_i.neg_input_isolate;
        ctrl_o.pos_cal_mid =
            cfg_i.pos_calibration_sel == bim_pkg::CAL_MID;
        ctrl_o.neg_cal_mid =
            cfg_i.neg_calibration_sel == bim_pkg::CAL_MID;
        // Current generator topology
        unique case (cfg_i.current_generator_mode)
            bim_pkg::CG_UNCH_LP: ctrl_o.cg_lowpass = 1'b1;
            bim_pkg::CG_CH_NOLP: ctrl_o.cg_chopped = 1'b1;
            bim_pkg::CG_CH_LP: begin
                ctrl_o.cg_chopped = 1'b1;
                ctrl_o.cg_lowpass = 1'b1;
            end
            bim_pkg::CG_CH_RCM: begin
                ctrl_o.cg_chopped = 1'b1;
                ctrl_o.cg_resistive_cm = 1'b1;
            end
        endcase
        // Self-test overrides drive routing and bias resistors
        ctrl_o.modulated_resistance_en = cfg_i.selftest_enable;
        if (cfg_i.selftest_enable) begin
            ctrl_o.drive_outputs_isolate = 1'b1;
            ctrl_o.drive_to_input_close = 1'b1;
            ctrl_o.pos_bias_connect = 1'b1;
            ctrl_o.neg_bias_connect = 1'b1;
            ctrl_o.bias_resistance_mohm = bim_pkg::RBIAS_SELFTEST;
        end
    end

endmodule : bim_decode

//--- verilog/bim_top.sv
/*
 * Configuration register bank of the bias and input multiplexer of a
 * single bioimpedance channel, an AHB-Lite slave with zero wait states.
 * Assumes one AHB-Lite master, word transfers, and a synchronous bus.
 */
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bim_top (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output bim_pkg::bim_ctrl_s ctrl_o
);

    // ==========================================================
    // State
    // ==========================================================
    // Whole state of the block in one record
    typedef struct packed {
        bim_pkg::bim_cfg_s cfg;      // Stored fields
        bim_pkg::bim_reg_e wr_sel;   // Register of a pending write
        logic [31:0] rdata;          // Read data of the data phase
        logic ready;                 // Ready out
        bim_pkg::bim_ctrl_s ctrl;    // Registered decoded controls
    } bim_state_s;

    bim_state_s state_ff;   // Current state
    bim_state_s nxt_state;  // Next state
    bim_pkg::bim_cfg_s cfg_wr; // Fields after the pending write
    bim_pkg::bim_ctrl_s dec;   // Decode of the fields

    // ==========================================================
    // Functions
    // ==========================================================
    // Byte address of a register index
    function automatic logic [31:0] idx_addr(input logic [7:0] idx);
        idx_addr = {22'h0, idx, 2'h0};
    endfunction : idx_addr

    // Which register a byte address selects
    function automatic bim_pkg::bim_reg_e addr_reg(
        input logic [31:0] addr
    );
        if (addr == idx_addr(bim_pkg::GEN_IDX)) begin
            addr_reg = bim_pkg::REG_GEN;
        end else if (addr == idx_addr(bim_pkg::BMUX_IDX)) begin
            addr_reg = bim_pkg::REG_BMUX;
        end else if (addr == idx_addr(bim_pkg::RATE_IDX)) begin
            addr_reg = bim_pkg::REG_RATE;
        end else begin
            addr_reg = bim_pkg::REG_NONE;
        end
    endfunction : addr_reg

    // Read image of one register; unassigned bits read zero
    function automatic logic [31:0] read_image(
        input bim_pkg::bim_reg_e sel,
        input bim_pkg::bim_cfg_s c
    );
        logic [31:0] v;
        v = 32'h0;
        unique case (sel)
            bim_pkg::REG_GEN: begin
                v[bim_pkg::GEN_MCLK_POS +: 2] = c.master_clock_sel;
                v[bim_pkg::GEN_CHEN_POS] = c.channel_enable;
                v[bim_pkg::GEN_VTH_POS +: 2] = c.leadoff_threshold_sel;
                v[bim_pkg::GEN_RBMODE_POS +: 2] = c.resistive_bias_mode;
                v[bim_pkg::GEN_RBSEL_POS +: 2] = c.bias_resistance_sel;
                v[bim_pkg::GEN_BIASP_POS] = c.pos_input_bias_en;
                v[bim_pkg::GEN_BIASN_POS] = c.neg_input_bias_en;
            end
            bim_pkg::REG_BMUX: begin
                v[bim_pkg::BMUX_ISOP_POS] = c.pos_input_isolate;
                v[bim_pkg::BMUX_ISON_POS] = c.neg_input_isolate;
                v[bim_pkg::BMUX_CALP_POS +: 2] = c.pos_calibration_sel;
                v[bim_pkg::BMUX_CALN_POS +: 2] = c.neg_calibration_sel;
                v[bim_pkg::BMUX_CG_POS +: 2] = c.current_generator_mode;
                v[bim_pkg::BMUX_BIST_POS] = c.selftest_enable;
            end
            bim_pkg::REG_RATE: begin
                v[bim_pkg::RATE_SEL_POS] = c.rate_half;
            end
            bim_pkg::REG_NONE: begin
                v = 32'h0;
            end
        endcase
        read_image = v;
    endfunction : read_image

    // Reset image of the stored fields
    function automatic bim_pkg::bim_cfg_s cfg_reset();
        bim_pkg::bim_cfg_s c;
        c.master_clock_sel = bim_pkg::RST_MCLK;
        c.channel_enable = bim_pkg::RST_CHEN;
        c.leadoff_threshold_sel = bim_pkg::RST_VTH;
        c.resistive_bias_mode = bim_pkg::RST_RBMODE;
        c.bias_resistance_sel = bim_pkg::RST_RBSEL;
        c.pos_input_bias_en = bim_pkg::RST_BIAS;
        c.neg_input_bias_en = bim_pkg::RST_BIAS;
        c.pos_input_isolate = bim_pkg::RST_ISO;
        c.neg_input_isolate = bim_pkg::RST_ISO;
        c.pos_calibration_sel = bim_pkg::RST_CAL;
        c.neg_calibration_sel = bim_pkg::RST_CAL;
        c.current_generator_mode = bim_pkg::RST_CG;
        c.selftest_enable = bim_pkg::RST_BIST;
        c.rate_half = bim_pkg::RST_RATE;
        cfg_reset = c;
    endfunction : cfg_reset

    // ==========================================================
    // Write data phase
    // ==========================================================
    // Applies the pending write; only assigned bits are taken
    always_comb begin
        cfg_wr = state_ff.cfg;
        unique case (state_ff.wr_sel)
            bim_pkg::REG_GEN: begin
                cfg_wr.master_clock_sel =
                    hwdata_i[bim_pkg::GEN_MCLK_POS +: 2];
                cfg_wr.channel_enable =
                    hwdata_i[bim_pkg::GEN_CHEN_POS];
                cfg_wr.leadoff_threshold_sel =
                    hwdata_i[bim_pkg::GEN_VTH_POS +: 2];
                cfg_wr.bias_resistance_sel =
                    hwdata_i[bim_pkg::GEN_RBSEL_POS +: 2];
                cfg_wr.pos_input_bias_en =
                    hwdata_i[bim_pkg::GEN_BIASP_POS];
                cfg_wr.neg_input_bias_en =
                    hwdata_i[bim_pkg::GEN_BIASN_POS];
                // Bias mode sticks at off unless channel is enabled
                if (state_ff.cfg.channel_enable ||
                    hwdata_i[bim_pkg::GEN_CHEN_POS]) begin
                    cfg_wr.resistive_bias_mode =
                        hwdata_i[bim_pkg::GEN_RBMODE_POS +: 2];
                end else begin
                    cfg_wr.resistive_bias_mode =
                        bim_pkg::RBMODE_OFF;
                end
            end
            bim_pkg::REG_BMUX: begin
                cfg_wr.pos_input_isolate =
                    hwdata_i[bim_pkg::BMUX_ISOP_POS];
                cfg_wr.neg_input_isolate =
                    hwdata_i[bim_pkg::BMUX_ISON_POS];
                cfg_wr.pos_calibration_sel =
                    hwdata_i[bim_pkg::BMUX_CALP_POS +: 2];
                cfg_wr.neg_calibration_sel =
                    hwdata_i[bim_pkg::BMUX_CALN_POS +: 2];
                cfg_wr.current_generator_mode =
                    hwdata_i[bim_pkg::BMUX_CG_POS +: 2];
                cfg_wr.selftest_enable =
                    hwdata_i[bim_pkg::BMUX_BIST_POS];
            end
            bim_pkg::REG_RATE: begin
                cfg_wr.rate_half = hwdata_i[bim_pkg::RATE_SEL_POS];
            end
            bim_pkg::REG_NONE: begin
                cfg_wr = state_ff.cfg; // Unmapped or no write
            end
        endcase
    end

    // ==========================================================
    // Decode of the updated fields
    // ==========================================================
    bim_decode u_decode (
        .cfg_i(cfg_wr),
        .ctrl_o(dec)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    // Address phase capture and read data preparation
    always_comb begin
        nxt_state = state_ff;
        nxt_state.cfg = cfg_wr;
        nxt_state.ctrl = dec;
        nxt_state.ready = 1'b1;       // Never inserts wait states
        nxt_state.wr_sel = bim_pkg::REG_NONE;
        // Transfer taken when selected, active and bus ready
        if (hsel_i && htrans_i[1] && hready_i) begin
            if (hwrite_i) begin
                nxt_state.wr_sel = addr_reg(haddr_i);
            end else begin
                // Read sees a write whose data phase is now
                nxt_state.rdata = read_image(addr_reg(haddr_i),
                    cfg_wr);
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // All state in one clocked process
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff.cfg <= cfg_reset();
            state_ff.wr_sel <= bim_pkg::REG_NONE;
            state_ff.rdata <= 32'h0;
            state_ff.ready <= 1'b1;
            state_ff.ctrl <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign hreadyout_o = state_ff.ready;
    assign hresp_o = 1'b0;              // Always OKAY
    assign hrdata_o = state_ff.rdata;
    assign ctrl_o = state_ff.ctrl;

endmodule : bim_top

//--- tb/bim_top_props.sv
/* Checker of bim_top port behaviour.
   Assumes zero-wait word transfers on AHB-Lite. */
`timescale 1ns/1ps
module bim_top_props (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire bim_pkg::bim_ctrl_s ctrl_o
);
    // ==========================================================
    // Transfer taken and checks
    // ==========================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic tk = hsel_i && htrans_i[1] && hready_i; // Address phase taken
    chk_vth_legal: assert property ($past(resetn_i) |->
        ctrl_o.leadoff_threshold_mv inside {10'h12C, 10'h190, 10'h1C2, 10'h1F4})
        else $error("threshold out of table");
    chk_rate_fast: assert property (ctrl_o.master_freq_chz == 22'h320000 |->
        ctrl_o.sample_rate_csps inside {13'h1900, 13'h0C80}
        && ctrl_o.cal_step_ns == 15'h7736) else $error("rate or step wrong");
    chk_bist_force: assert property (ctrl_o.modulated_resistance_en |->
        ctrl_o.bias_resistance_mohm == 8'hC8 && ctrl_o.pos_bias_connect
        && ctrl_o.neg_bias_connect && ctrl_o.drive_outputs_isolate
        && ctrl_o.drive_to_input_close) else $error("self-test not forced");
    chk_bias_gate: assert property ((ctrl_o.pos_bias_connect ||
        ctrl_o.neg_bias_connect) && !ctrl_o.modulated_resistance_en
        |-> ctrl_o.channel_power) else $error("bias without channel");
    chk_cg_modes: assert property ($past(resetn_i) |-> {ctrl_o.cg_chopped,
        ctrl_o.cg_lowpass, ctrl_o.cg_resistive_cm} inside
        {3'h2, 3'h4, 3'h6, 3'h5}) else $error("bad generator mode");
    chk_gen_write: assert property (tk && hwrite_i && haddr_i == 32'h40
        ##1 1 |=> ctrl_o.channel_power == $past(hwdata_i[18])
        && ctrl_o.master_clock_sel == $past(hwdata_i[21:20]))
        else $error("general write not applied");
    chk_iso_write: assert property (tk && hwrite_i && haddr_i == 32'h5C
        ##1 1 |=> ctrl_o.pos_input_connect == !$past(hwdata_i[21])
        && ctrl_o.neg_input_connect == !$past(hwdata_i[20]))
        else $error("isolate write not applied");
    chk_hole_read: assert property (tk && !hwrite_i && !(haddr_i inside
        {32'h40, 32'h5C, 32'h80}) |=> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    cov_bist: cover property (ctrl_o.modulated_resistance_en);
    cov_bias: cover property (ctrl_o.pos_bias_connect && ctrl_o.channel_power);
    cov_read: cover property (tk && !hwrite_i);
endmodule : bim_top_props
bind bim_top bim_top_props u_props (.sys_clk_i, .resetn_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .ctrl_o);

//--- tb/bim_top_bench.sv
/* Self-checking bench of bim_top with random register traffic.
   Assumes a zero-wait slave whose hreadyout is looped to hready. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    miscompares++; $display("Error %s exp %h got %h", n, e, s); end end
module bim_top_bench;
    logic sys_clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic hsel_i = 1'h0;
    logic hwrite_i = 1'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, sd, g, b, q, d, nx;
    logic hreadyout_o, hresp_o, r;
    bim_pkg::bim_ctrl_s ctrl_o;
    int miscompares = 0;
    int cmp_count = 0;
    // Rate, threshold and bias tables
    logic [12:0] rt [8] = '{13'h1900, 13'h0C80, 13'h186A, 13'h0C35,
        13'h1388, 13'h09C4, 13'h1383, 13'h09C2};
    logic [9:0] vt [4] = '{10'h12C, 10'h190, 10'h1C2, 10'h1F4};
    logic [7:0] bt [4] = '{8'h32, 8'h64, 8'hC8, 8'h00};
    bim_top uut (.sys_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
        .hreadyout_o, .hresp_o, .hrdata_o, .ctrl_o);
    initial forever #25 sys_clk_i = ~sys_clk_i;
    // ==========================================================
    // Expectation and helpers
    // ==========================================================
    function automatic logic [31:0] lf(input logic [31:0] x);
        lf = {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lf
    function automatic bim_pkg::bim_ctrl_s ex(input logic [31:0] g, b, input logic r);
        bim_pkg::bim_ctrl_s c;
        logic [1:0] m;
        m = g[21:20];
        c = '0;
        c.channel_power = g[18];
        c.master_clock_sel = m;
        c.master_freq_chz = m == 0 ? 22'h320000 : m == 3 ? 22'h30C7CE : 22'h30D400;
        c.cal_step_ns = m == 0 ? 15'h7736 : m == 3 ? 15'h7A31 : 15'h7A12;
        c.sample_rate_csps = rt[{m, r}];
        c.leadoff_threshold_mv = vt[g[7:6]];
        c.bias_resistance_mohm = b[11] ? 8'hC8 : bt[g[3:2]];
        c.pos_bias_connect = b[11] | (g[1] & g[5:4] == 2 & g[18]);
        c.neg_bias_connect = b[11] | (g[0] & g[5:4] == 2 & g[18]);
        c.pos_input_connect = !b[21];
        c.neg_input_connect = !b[20];
        c.pos_cal_mid = b[19:18] == 1;
        c.neg_cal_mid = b[17:16] == 1;
        c.cg_chopped = b[13:12] != 0;
        c.cg_lowpass = b[13:12] == 0 || b[13:12] == 2;
        c.cg_resistive_cm = b[13:12] == 3;
        c.modulated_resistance_en = b[11];
        c.drive_outputs_isolate = b[11];
        c.drive_to_input_close = b[11];
        return c;
    endfunction : ex
    task wrap_up;
        if (miscompares == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // Bounded wait for hready at a rising edge
    task automatic rdy;
        int n = 0;
        do begin @(posedge sys_clk_i); n++; end
        while (hreadyout_o !== 1'h1 && n < 40);
        if (n >= 40) begin miscompares++; wrap_up(); end
    endtask : rdy
    // One single word transfer, read data left in q
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] v);
        hsel_i <= 1'h1; haddr_i <= a; hwrite_i <= w; htrans_i <= 2'h2;
        rdy();
        hsel_i <= 1'h0; htrans_i <= 2'h0; hwdata_i <= v;
        rdy();
        q = hrdata_o;
    endtask : bus
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (8) @(posedge sys_clk_i);
        `CHK("ctrl in reset", '0, ctrl_o)
        sd = 32'h85A95CD7;
        for (int i = 0; i < 30; i++) begin
            if (i == 0 || i == 15) begin // Reset images, also mid-run
                if (i == 15) begin resetn_i <= 1'h0; @(posedge sys_clk_i); end
                resetn_i <= 1'h1;
                g = 32'h4; b = 32'h300000; r = 1'h0;
            end
            bus(32'h40, 1'h0, 32'h0); `CHK("gen", g, q)
            bus(32'h5C, 1'h0, 32'h0); `CHK("bmux", b, q)
            bus(32'h80, 1'h0, 32'h0); `CHK("rate", {31'h0, r}, q)
            `CHK("ctrl", ex(g, b, r), ctrl_o)
            bus(32'h84 + {sd[5:0], 2'h0}, 1'h0, 32'h0); `CHK("hole", 32'h0, q)
            `CHK("resp", 2'h1, {hresp_o, hreadyout_o})
            sd = lf(sd);
            d = i == 0 ? 32'h22 : i == 1 ? 32'h40023 : sd; // Mode without then with enable
            d[4] = 1'h0;
            if (d[3:2] == 2'h3) d[2] = 1'h0;
            nx = d & 32'h003400FF;
            if (!(g[18] | d[18])) nx[5:4] = 2'h0;
            bus(32'h40, 1'h1, d); g = nx;
            sd = lf(sd); d = sd; d[19] = 1'h0; d[17] = 1'h0;
            if (d[11]) d[21:20] = 2'h3;
            bus(32'h5C, 1'h1, d); b = d & 32'h003F3800;
            sd = lf(sd); bus(32'h80, 1'h1, sd); r = sd[0];
            bus(32'h84 + {sd[7:2], 2'h0}, 1'h1, sd); // Ignored write
        end
        wrap_up();
    end
endmodule : bim_top_bench
